//--- common/qpc_pkg.sv
// constants and types shared by the quad pot command unit
package qpc_pkg;
   // device-type identifier; the value is arbitrary
   localparam logic [3:0]  DEVICE_TYPE_ID    = 4'ha;
   // instruction opcodes, upper nibble of the instruction byte
   localparam logic [3:0]  OP_READ_WIPER     = 4'h9;
   localparam logic [3:0]  OP_WRITE_WIPER    = 4'ha;
   localparam logic [3:0]  OP_READ_PRESET    = 4'hb;
   localparam logic [3:0]  OP_WRITE_PRESET   = 4'hc;
   localparam logic [3:0]  OP_COPY_TO_WIPER  = 4'hd;
   localparam logic [3:0]  OP_SAVE_WIPER     = 4'he;
   localparam logic [3:0]  OP_GLOBAL_COPY    = 4'h1;
   localparam logic [3:0]  OP_GLOBAL_SAVE    = 4'h8;
   localparam logic [3:0]  OP_STEP           = 4'h2;
   // instruction byte fields
   localparam int          OPC_MSB           = 7;
   localparam int          OPC_LSB           = 4;
   localparam int          PRESET_SEL_HI     = 3;
   localparam int          PRESET_SEL_LO     = 2;
   localparam int          POT_SEL_HI        = 1;
   localparam int          POT_SEL_LO        = 0;
   // sizes
   localparam int          NUM_POTS          = 4;
   localparam int          NUM_TAPS          = 256;
   localparam int          NUM_PRESET_WORDS  = 16;
   localparam logic [3:0]  BYTE_BITS         = 4'h8;
   localparam int          SYNC_W            = 6;
   localparam int          NV_CNT_W          = 20;
   // values
   localparam logic [7:0]  WIPER_RST         = 8'h00;
   localparam logic [7:0]  WIPER_MAX         = 8'hff;
   localparam logic [7:0]  WIPER_MIN         = 8'h00;
   localparam logic [7:0]  PRESET_ERASED     = 8'h00;
   localparam logic [1:0]  PRESET_ZERO       = 2'h0;
   localparam logic [NUM_TAPS-1:0] TAP_RST   = 256'h1;
   // timing
   localparam int unsigned CLK_FREQ_KHZ      = 100000;
   localparam int unsigned NV_WRITE_TIME_MS  = 10;
   localparam int unsigned NV_WRITE_CYCLES   = NV_WRITE_TIME_MS * CLK_FREQ_KHZ;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INSTR, ST_ACK_INSTR,
      ST_DATA, ST_ACK_DATA, ST_TX, ST_MASTER_ACKNOWLEDGE, ST_STEP, ST_WAIT
   } qpc_state_t;

   typedef enum logic [1:0] {
      SAVE_NONE, SAVE_DATA, SAVE_WIPER, SAVE_ALL
   } qpc_save_t;
endpackage

//--- rtl/qpc_sync.sv
// two-flop synchroniser for the serial pins and address straps
`timescale 1ns/1ps
`default_nettype none
module qpc_sync (
   input  wire logic                      clk_i,
   input  wire logic                      reset_i,
   input  wire logic [qpc_pkg::SYNC_W-1:0] async_i,
   output logic      [qpc_pkg::SYNC_W-1:0] sync_o
);
   import qpc_pkg::*;

   genvar b;
   generate
      for (b = 0; b < SYNC_W; b++) begin : g_bit
         logic meta_r;
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               meta_r    <= 1'b1;
               sync_o[b] <= 1'b1;
            end else begin
               meta_r    <= async_i[b];
               sync_o[b] <= meta_r;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- rtl/qpc_tap_decode.sv
// registered one-of-256 tap switch decode for one pot
`timescale 1ns/1ps
`default_nettype none
module qpc_tap_decode (
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   input  wire logic [7:0]                  wiper_i,
   output logic      [qpc_pkg::NUM_TAPS-1:0] tap_o
);
   import qpc_pkg::*;

   genvar t;
   generate
      for (t = 0; t < NUM_TAPS; t++) begin : g_tap
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               tap_o[t] <= TAP_RST[t];
            end else begin
               tap_o[t] <= (wiper_i == 8'(t));
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- rtl/qpc_unit.sv
// serial command decoder and wiper/preset registers of the quad pot
`timescale 1ns/1ps
`default_nettype none
module qpc_unit #(
   parameter int unsigned NV_CYCLES = qpc_pkg::NV_WRITE_CYCLES
) (
   input  wire logic                         clk_i,
   input  wire logic                         reset_i,
   input  wire logic                         scl_i,
   input  wire logic                         sda_i,
   input  wire logic [3:0]                   pin_address_bits_i,
   output logic                              sda_o,
   output logic                              sda_oe_n_o,
   output logic                              prog_busy_o,
   output logic      [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot0_o,
   output logic      [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot1_o,
   output logic      [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot2_o,
   output logic      [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot3_o
);
   import qpc_pkg::*;

   logic [SYNC_W-1:0]   sync_w;
   logic                scl_s;
   logic                sda_s;
   logic [3:0]          addr_s;
   logic                scl_d_r;
   logic                sda_d_r;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_cond;
   logic                stop_cond;
   qpc_state_t          state_r;
   logic [3:0]          bit_cnt_r;
   logic [7:0]          shift_r;
   logic [7:0]          instr_r;
   logic [7:0]          tx_r;
   logic                recall_r;
   qpc_save_t           save_r;
   logic [7:0]          save_data_r;
   logic                busy_r;
   logic [NV_CNT_W-1:0] nv_cnt_r;
   logic                oe_n_r;
   // nonvolatile store: no reset, so contents survive reset; erased at start of life
   logic [7:0]          preset_mem [NUM_PRESET_WORDS] = '{default: PRESET_ERASED};
   logic [7:0]          wiper_w [NUM_POTS];
   logic [NUM_TAPS-1:0] tap_w [NUM_POTS];
   logic [3:0]          opcode;
   logic [1:0]          pot_sel;
   logic [1:0]          preset_sel;
   logic [3:0]          rx_opcode;
   logic                rx_op_ok;
   logic                byte_done;
   logic                addr_hit;
   logic                instr_take;
   logic                data_take;
   logic                instr_ack_end;
   logic                read_op;
   logic [7:0]          read_val;
   logic                wiper_load;
   logic [7:0]          wiper_load_val;
   logic                global_copy;
   logic                step_evt;
   logic                commit;

   qpc_sync u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({scl_i, sda_i, pin_address_bits_i}),
      .sync_o  (sync_w)
   );

   assign scl_s  = sync_w[5];
   assign sda_s  = sync_w[4];
   assign addr_s = sync_w[3:0];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // our own data changes only while the clock is low, so it never fakes a start or stop
   assign scl_rise   = scl_s & ~scl_d_r;
   assign scl_fall   = ~scl_s & scl_d_r;
   assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   assign opcode     = instr_r[OPC_MSB:OPC_LSB];
   assign pot_sel    = instr_r[POT_SEL_HI:POT_SEL_LO];
   assign preset_sel = instr_r[PRESET_SEL_HI:PRESET_SEL_LO];
   assign rx_opcode  = shift_r[OPC_MSB:OPC_LSB];

   // only the opcode nibble is checked; filler bits are don't-care
   assign rx_op_ok = rx_opcode inside {OP_READ_WIPER, OP_WRITE_WIPER, OP_READ_PRESET,
                                       OP_WRITE_PRESET, OP_COPY_TO_WIPER, OP_SAVE_WIPER,
                                       OP_GLOBAL_COPY, OP_GLOBAL_SAVE, OP_STEP};

   assign byte_done     = scl_fall && (bit_cnt_r == BYTE_BITS);
   assign addr_hit      = (shift_r[7:4] == DEVICE_TYPE_ID) && (shift_r[3:0] == addr_s);
   assign instr_take    = (state_r == ST_INSTR) && byte_done && rx_op_ok;
   assign data_take     = (state_r == ST_DATA) && byte_done;
   assign instr_ack_end = (state_r == ST_ACK_INSTR) && scl_fall;
   assign read_op       = (opcode == OP_READ_WIPER) || (opcode == OP_READ_PRESET);
   assign read_val      = (opcode == OP_READ_WIPER) ? wiper_w[pot_sel]
                                                    : preset_mem[{pot_sel, preset_sel}];
   assign global_copy   = instr_ack_end && (opcode == OP_GLOBAL_COPY);
   assign step_evt      = (state_r == ST_STEP) && scl_fall;
   assign commit        = stop_cond && (save_r != SAVE_NONE) && !busy_r;

   always_comb begin
      wiper_load     = 1'b0;
      wiper_load_val = shift_r;
      if (data_take && (opcode == OP_WRITE_WIPER)) begin
         wiper_load     = 1'b1;
      end else if (instr_ack_end && (opcode == OP_COPY_TO_WIPER)) begin
         wiper_load     = 1'b1;
         wiper_load_val = preset_mem[{pot_sel, preset_sel}];
      end
   end

   // frame sequencing
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         instr_r   <= 8'h00;
      end else if (start_cond) begin
         state_r   <= busy_r ? ST_WAIT : ST_ADDR;
         bit_cnt_r <= 4'h0;
      end else if (stop_cond) begin
         state_r   <= ST_IDLE;
      end else begin
         if (scl_rise && ((state_r == ST_ADDR) || (state_r == ST_INSTR) ||
                          (state_r == ST_DATA) || (state_r == ST_TX))) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r   <= {shift_r[6:0], sda_s};
         end
         unique case (state_r)
            ST_ADDR: begin
               if (byte_done) begin
                  state_r <= addr_hit ? ST_ACK_ADDR : ST_WAIT;
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  state_r   <= ST_INSTR;
                  bit_cnt_r <= 4'h0;
               end
            end
            ST_INSTR: begin
               if (byte_done) begin
                  instr_r <= shift_r;
                  state_r <= rx_op_ok ? ST_ACK_INSTR : ST_WAIT;
               end
            end
            ST_ACK_INSTR: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (read_op) begin
                     state_r <= ST_TX;
                  end else if ((opcode == OP_WRITE_WIPER) || (opcode == OP_WRITE_PRESET)) begin
                     state_r <= ST_DATA;
                  end else if (opcode == OP_STEP) begin
                     state_r <= ST_STEP;
                  end else begin
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_DATA, ST_TX: begin
               if (byte_done) begin
                  state_r <= (state_r == ST_DATA) ? ST_ACK_DATA : ST_MASTER_ACKNOWLEDGE;
               end
            end
            ST_ACK_DATA, ST_MASTER_ACKNOWLEDGE: begin
               if (scl_fall) begin
                  state_r <= ST_WAIT;
               end
            end
            ST_IDLE, ST_STEP, ST_WAIT: ;
         endcase
      end
   end

   // open-drain data: drive low for acknowledge and zero bits, otherwise release
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         oe_n_r <= 1'b1;
         tx_r   <= 8'h00;
      end else if (start_cond || stop_cond) begin
         oe_n_r <= 1'b1;
      end else if (((state_r == ST_ADDR) && byte_done && addr_hit) ||
                   instr_take || data_take) begin
         oe_n_r <= 1'b0;
      end else if (instr_ack_end && read_op) begin
         oe_n_r <= read_val[7];
         tx_r   <= {read_val[6:0], 1'b0};
      // byte_done also ends a read byte, freeing the line for the master acknowledge
      end else if (scl_fall && ((state_r == ST_ACK_ADDR) || (state_r == ST_ACK_INSTR) ||
                                (state_r == ST_ACK_DATA) || byte_done)) begin
         oe_n_r <= 1'b1;
      end else if ((state_r == ST_TX) && scl_fall) begin
         oe_n_r <= tx_r[7];
         tx_r   <= {tx_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= oe_n_r;
      end
   end

   // power-up recall takes one cycle after reset release
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         recall_r <= 1'b1;
      end else begin
         recall_r <= 1'b0;
      end
   end

   // pending nonvolatile change, committed only when the frame closes with stop
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         save_r      <= SAVE_NONE;
         save_data_r <= 8'h00;
      end else if (start_cond || stop_cond) begin
         save_r <= SAVE_NONE;
      end else if (data_take && (opcode == OP_WRITE_PRESET)) begin
         save_r      <= SAVE_DATA;
         save_data_r <= shift_r;
      end else if (instr_ack_end && (opcode == OP_SAVE_WIPER)) begin
         save_r <= SAVE_WIPER;
      end else if (instr_ack_end && (opcode == OP_GLOBAL_SAVE)) begin
         save_r <= SAVE_ALL;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_r   <= 1'b0;
         nv_cnt_r <= '0;
      end else if (commit) begin
         busy_r   <= 1'b1;
         nv_cnt_r <= NV_CNT_W'(NV_CYCLES - 1);
      end else if (busy_r) begin
         if (nv_cnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            nv_cnt_r <= nv_cnt_r - NV_CNT_W'(1);
         end
      end
   end

   assign prog_busy_o = busy_r;

   always_ff @(posedge clk_i) begin
      if (commit) begin
         unique case (save_r)
            SAVE_DATA:  preset_mem[{pot_sel, preset_sel}] <= save_data_r;
            SAVE_WIPER: preset_mem[{pot_sel, preset_sel}] <= wiper_w[pot_sel];
            SAVE_ALL: begin
               for (int p = 0; p < NUM_POTS; p++) begin
                  preset_mem[{2'(p), preset_sel}] <= wiper_w[p];
               end
            end
            SAVE_NONE: ;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_POTS; g++) begin : g_pot
         logic [7:0] wiper_r;
         // volatile: reset clears it before the preset zero recall
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               wiper_r <= WIPER_RST;
            end else if (recall_r) begin
               wiper_r <= preset_mem[{2'(g), PRESET_ZERO}];
            end else if (wiper_load && (pot_sel == 2'(g))) begin
               wiper_r <= wiper_load_val;
            end else if (global_copy) begin
               wiper_r <= preset_mem[{2'(g), preset_sel}];
            end else if (step_evt && (pot_sel == 2'(g))) begin
               if (sda_s && (wiper_r != WIPER_MAX)) begin
                  wiper_r <= wiper_r + 8'h01;
               end else if (!sda_s && (wiper_r != WIPER_MIN)) begin
                  wiper_r <= wiper_r - 8'h01;
               end
            end
         end
         assign wiper_w[g] = wiper_r;

         qpc_tap_decode u_tap (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .wiper_i (wiper_r),
            .tap_o   (tap_w[g])
         );
      end
   endgenerate

   assign tap_sel_pot0_o = tap_w[0];
   assign tap_sel_pot1_o = tap_w[1];
   assign tap_sel_pot2_o = tap_w[2];
   assign tap_sel_pot3_o = tap_w[3];
endmodule
`default_nettype wire

//--- bench/qpc_unit_properties.sv
// port assertions for the quad pot command unit
`timescale 1ns/1ps
`default_nettype none
module qpc_unit_properties #(
   parameter int unsigned NV_CYCLES = 50
) (
   input wire logic                         clk_i,
   input wire logic                         reset_i,
   input wire logic                         scl_i,
   input wire logic                         sda_i,
   input wire logic [3:0]                   pin_address_bits_i,
   input wire logic                         sda_o,
   input wire logic                         sda_oe_n_o,
   input wire logic                         prog_busy_o,
   input wire logic [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot0_o,
   input wire logic [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot1_o,
   input wire logic [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot2_o,
   input wire logic [qpc_pkg::NUM_TAPS-1:0] tap_sel_pot3_o
);
   import qpc_pkg::*;
   logic [19:0] busy_cnt_r;
   logic [3:0]  quiet_r;
   logic        scl_q_r;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_cnt_r <= 20'h0;
      end else begin
         busy_cnt_r <= prog_busy_o ? busy_cnt_r + 20'h1 : 20'h0;
      end
   end
   // cycles since the serial clock last fell, saturating
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_q_r <= 1'b0;
         quiet_r <= 4'h0;
      end else begin
         scl_q_r <= scl_i;
         quiet_r <= (scl_q_r && !scl_i) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence busy_start_s;
      $rose(prog_busy_o);
   endsequence
   sequence busy_hold_s;
      prog_busy_o [*8];
   endsequence
   tap_onehot_a:
      assert property ($onehot(tap_sel_pot0_o) && $onehot(tap_sel_pot1_o)
         && $onehot(tap_sel_pot2_o) && $onehot(tap_sel_pot3_o)) else $error("tap not one-hot");
   open_drain_a:
      assert property (sda_o == 1'b0) else $error("sda driven high");
   busy_quiet_a:
      assert property (prog_busy_o |-> sda_oe_n_o) else $error("ack while busy");
   busy_span_a:
      assert property ($fell(prog_busy_o) |-> busy_cnt_r == NV_CYCLES)
         else $error("busy length wrong");
   busy_hold_a:
      assert property (busy_start_s |-> busy_hold_s) else $error("busy dropped early");
   busy_after_stop_a:
      assert property ($rose(prog_busy_o) |-> scl_i && sda_i) else $error("busy not after stop");
   ack_low_phase_a:
      assert property ($changed(sda_oe_n_o) |-> !$past(scl_i, 2)) else $error("sda moved in high");
   drive_bounded_a:
      assert property ($fell(sda_oe_n_o) |-> ##[1:100] sda_oe_n_o) else $error("sda held low");
   tap_after_fall_a:
      assert property ($changed({tap_sel_pot0_o, tap_sel_pot1_o, tap_sel_pot2_o,
         tap_sel_pot3_o}) |-> quiet_r < 4'ha) else $error("tap changed without clock");
endmodule
bind qpc_unit qpc_unit_properties #(.NV_CYCLES(NV_CYCLES)) props (
   .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
   .pin_address_bits_i(pin_address_bits_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .prog_busy_o(prog_busy_o), .tap_sel_pot0_o(tap_sel_pot0_o),
   .tap_sel_pot1_o(tap_sel_pot1_o), .tap_sel_pot2_o(tap_sel_pot2_o),
   .tap_sel_pot3_o(tap_sel_pot3_o));
`default_nettype wire

//--- bench/qpc_host_model.sv
// two-wire bus master model driving frames into the unit
`timescale 1ns/1ps
`default_nettype none
module qpc_host_model (
   input  wire logic clk_i,
   input  wire logic sda_wire_i,
   output logic      scl_o,
   output logic      sda_drv_o
);
   // bus idles high; the clock only runs inside frames
   initial begin
      scl_o = 1'b1;
      sda_drv_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic start_frame();
      sda_drv_o <= 1'b0;
      tick(4);
      scl_o <= 1'b0;
      tick(2);
   endtask
   // long bus-free tail so stop is seen before the next start
   task automatic stop_frame();
      sda_drv_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_drv_o <= 1'b1;
      tick(8);
   endtask
   // data moves mid-low, sampled at the end of the high phase
   task automatic xbit(input logic b, output logic r);
      sda_drv_o <= b;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      r = sda_wire_i;
      scl_o <= 1'b0;
      tick(2);
   endtask
   task automatic xbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], r);
      xbit(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
      xbit(1'b0, r);
   endtask
endmodule
`default_nettype wire

//--- bench/qpc_unit_bench.sv
// self-checking bench for the quad pot command unit
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module qpc_unit_bench;
   import qpc_pkg::*;
   localparam int unsigned NV = 50;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [3:0]          straps;
   logic                scl, sda_drv, sda_w, sda_o, sda_oe_n, busy;
   logic [NUM_TAPS-1:0] tap [4];
   logic [7:0]          wip [4] = '{default: WIPER_RST};
   logic [7:0]          pre [4][4] = '{default: PRESET_ERASED};
   int                  fails = 0;
   int                  compares = 0;
   int                  seed = 5;
   always #5 clk = ~clk;
   assign sda_w = sda_drv & (sda_oe_n ? 1'b1 : sda_o);
   qpc_host_model host (.clk_i(clk), .sda_wire_i(sda_w), .scl_o(scl), .sda_drv_o(sda_drv));
   qpc_unit #(.NV_CYCLES(NV)) DUT (
      .clk_i(clk), .reset_i(rst), .scl_i(scl), .sda_i(sda_w),
      .pin_address_bits_i(straps), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .prog_busy_o(busy), .tap_sel_pot0_o(tap[0]), .tap_sel_pot1_o(tap[1]),
      .tap_sel_pot2_o(tap[2]), .tap_sel_pot3_o(tap[3]));
   function automatic logic [7:0] rnd();
      logic [31:0] v;
      v = $random(seed);
      return v[7:0];
   endfunction
   function automatic logic [NUM_TAPS-1:0] tap_of(input logic [7:0] w);
      return {{(NUM_TAPS-1){1'b0}}, 1'b1} << w;
   endfunction
   function automatic logic [7:0] stepped(input logic [7:0] w, input logic up, input int n);
      logic [7:0] r;
      r = w;
      repeat (n) r = up ? (r == WIPER_MAX ? r : r + 8'h1) : (r == WIPER_MIN ? r : r - 8'h1);
      return r;
   endfunction
   task automatic tally_and_finish();
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic head(input logic [3:0] op, input logic [1:0] sel, input logic [1:0] pot);
      logic a;
      host.start_frame();
      host.xbyte({DEVICE_TYPE_ID, straps}, a);
      `CHECK("address ack", 1'b1, a)
      host.xbyte({op, sel, pot}, a);
      `CHECK("instr ack", 1'b1, a)
   endtask
   task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic [1:0] pot);
      head(op, sel, pot);
      host.stop_frame();
   endtask
   task automatic wr(input logic [3:0] op, input logic [1:0] sel, input logic [1:0] pot,
                     input logic [7:0] v);
      logic a;
      head(op, sel, pot);
      host.xbyte(v, a);
      `CHECK("data ack", 1'b1, a)
      host.stop_frame();
   endtask
   task automatic rd(input logic [3:0] op, input logic [1:0] sel, input logic [1:0] pot,
                     output logic [7:0] d);
      head(op, sel, pot);
      host.rbyte(d);
      host.stop_frame();
   endtask
   // optional probe: a frame started while programming must be ignored
   task automatic finish_nv(input logic probe);
      int n;
      logic a;
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      `CHECK("busy start", 1'b1, busy)
      if (probe) begin
         host.start_frame();
         host.xbyte({DEVICE_TYPE_ID, straps}, a);
         `CHECK("busy ack", 1'b0, a)
         host.stop_frame();
      end
      n = 0;
      while (busy !== 1'b0 && n < NV + 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= NV + 20) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic check_all();
      logic [7:0] d;
      for (int p = 0; p < NUM_POTS; p++) begin
         `CHECK("tap select", tap_of(wip[p]), tap[p])
         rd(OP_READ_WIPER, 2'h0, p[1:0], d);
         `CHECK("wiper read", wip[p], d)
      end
   endtask
   task automatic step(input logic [1:0] pot, input logic up, input int n);
      logic r;
      head(OP_STEP, 2'h0, pot);
      repeat (n) host.xbit(up, r);
      host.stop_frame();
      wip[pot] = stepped(wip[pot], up, n);
   endtask
   task automatic check_presets();
      logic [7:0] d;
      for (int p = 0; p < 4; p++) begin
         for (int r = 0; r < 4; r++) begin
            rd(OP_READ_PRESET, r[1:0], p[1:0], d);
            `CHECK("preset read", pre[p][r], d)
         end
      end
   endtask
   initial begin
      logic [7:0] v;
      logic [1:0] s;
      logic       a;
      v = rnd();
      straps <= v[3:0];
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      check_all();
      for (int p = 0; p < 4; p++) begin
         v = rnd();
         wr(OP_WRITE_WIPER, 2'h0, p[1:0], v);
         wip[p] = v;
      end
      check_all();
      wr(OP_WRITE_WIPER, 2'h0, 2'h0, 8'hfe);
      wip[0] = 8'hfe;
      step(2'h0, 1'b1, 3);
      wr(OP_WRITE_WIPER, 2'h0, 2'h1, 8'h01);
      wip[1] = 8'h01;
      step(2'h1, 1'b0, 3);
      step(2'h2, 1'b1, 2);
      check_all();
      for (int p = 0; p < 4; p++) begin
         for (int r = 0; r < 4; r++) begin
            v = rnd();
            wr(OP_WRITE_PRESET, r[1:0], p[1:0], v);
            pre[p][r] = v;
            finish_nv(p == 3 && r == 3);
         end
      end
      check_presets();
      host.start_frame();
      host.xbyte({DEVICE_TYPE_ID, ~straps}, a);
      `CHECK("foreign ack", 1'b0, a)
      host.stop_frame();
      host.start_frame();
      host.xbyte({DEVICE_TYPE_ID, straps}, a);
      `CHECK("address ack", 1'b1, a)
      host.xbyte(8'hf0, a);
      `CHECK("bad opcode ack", 1'b0, a)
      host.stop_frame();
      for (int p = 0; p < 4; p++) begin
         v = rnd();
         cmd(OP_COPY_TO_WIPER, v[1:0], p[1:0]);
         wip[p] = pre[p][v[1:0]];
      end
      check_all();
      v = rnd();
      wr(OP_WRITE_WIPER, 2'h0, 2'h2, v);
      wip[2] = v;
      s = v[5:4];
      cmd(OP_SAVE_WIPER, s, 2'h2);
      finish_nv(1'b0);
      pre[2][s] = wip[2];
      check_presets();
      cmd(OP_GLOBAL_COPY, s + 2'h1, 2'h0);
      for (int p = 0; p < 4; p++) wip[p] = pre[p][s + 2'h1];
      check_all();
      step(2'h3, 1'b0, 1);
      cmd(OP_GLOBAL_SAVE, s, 2'h0);
      finish_nv(1'b0);
      for (int p = 0; p < 4; p++) pre[p][s] = wip[p];
      check_presets();
      rd(OP_READ_WIPER, 2'h3, 2'h1, v);
      `CHECK("filler read", wip[1], v)
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      for (int p = 0; p < 4; p++) wip[p] = pre[p][PRESET_ZERO];
      check_all();
      tally_and_finish();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
